/* dv/gak_host_model.sv */
// Purpose: Host side of the system control port
// Assumes: Writes are single cycles at the falling edge
// Notes:   Address stays on the port so readback is continuous
`timescale 1ns/10ps
module gak_host_model (
    input  wire logic        i_mclk,
    output logic             o_io_wr,
    output logic      [15:0] o_io_addr,
    output logic      [7:0]  o_io_wdata
);
    initial begin
        o_io_wr    = 1'b0;
        o_io_addr  = 16'h0092;
        o_io_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] v);
        @(negedge i_mclk);
        o_io_wr    = 1'b1;
        o_io_wdata = v;
        @(negedge i_mclk);
        o_io_wr    = 1'b0;
        // Released data lines must not keep showing the byte
        o_io_wdata = ~v;
    endtask : wr
    task automatic reset_req(input logic g);
        wr({6'h00, g, 1'b0});
        wr({6'h00, g, 1'b1});
    endtask : reset_req
endmodule : gak_host_model

/* dv/gak_top_bench.sv */
// Purpose: Self-checking bench for the gate/keyboard-reset fast path
// Assumes: i_mclk stands for the selected controller clock
// Notes:   Expected results queue up with their due cycle
`timescale 1ns/10ps
module gak_top_bench;
    logic        i_mclk, i_rst, i_cfg_wr, i_ctl_wr, i_ctl_is_cmd, i_fw_gate, i_fw_reset_n;
    logic        i_io_wr, o_address_line_gate, o_keyboard_reset_out_n, g, s, rn;
    logic [7:0]  i_cfg_idx, i_cfg_wdata, i_ctl_byte, i_io_wdata, o_cfg_rdata, o_io_rdata, b;
    logic [15:0] i_io_addr;
    logic [41:0] q[$];
    logic [41:0] e;
    int          cyc, n_mismatch, num_checks, seed, d, p;
    int          mhz[4] = '{6, 8, 12, 16};

    gak_top gak_top_inst (.i_mclk, .i_rst, .i_cfg_wr, .i_cfg_idx, .i_cfg_wdata, .o_cfg_rdata,
        .i_io_wr, .i_io_addr, .i_io_wdata, .o_io_rdata, .i_ctl_wr, .i_ctl_is_cmd, .i_ctl_byte,
        .i_fw_gate, .i_fw_reset_n, .o_address_line_gate, .o_keyboard_reset_out_n);
    gak_host_model gak_host_model_inst (.i_mclk, .o_io_wr(i_io_wr), .o_io_addr(i_io_addr),
        .o_io_wdata(i_io_wdata));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) cyc <= cyc + 1;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic note(input int dt, input logic [1:0] sel, input logic [7:0] v);
        q.push_back({cyc + dt, sel, v});
    endtask : note
    task automatic wrap_up;
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic cfg(input logic [7:0] v);
        @(negedge i_mclk);
        i_cfg_wr    = 1'b1;
        i_cfg_wdata = v;
        @(negedge i_mclk);
        i_cfg_wr    = 1'b0;
        note(2, 2'd0, v & 8'hc7);
    endtask : cfg
    task automatic ctl(input logic c, input logic [7:0] v);
        @(negedge i_mclk);
        i_ctl_wr     = 1'b1;
        i_ctl_is_cmd = c;
        i_ctl_byte   = v;
        @(negedge i_mclk);
        i_ctl_wr     = 1'b0;
    endtask : ctl
    task automatic fw(input logic fg, input logic fr);
        @(negedge i_mclk);
        i_fw_gate    = fg;
        i_fw_reset_n = fr;
    endtask : fw
    // Edges around the fall and the rise pin both least times exactly
    task automatic pulse;
        note(d, 2'd3, 8'h01);
        note(d + 1, 2'd3, 8'h00);
        note(d + p, 2'd3, 8'h00);
        note(d + p + 1, 2'd3, 8'h01);
        repeat (d + p + 12) @(negedge i_mclk);
    endtask : pulse

    always @(negedge i_mclk) begin
        while (q.size() > 0 && q[0][41:10] <= cyc) begin
            e = q.pop_front();
            case (e[9:8])
                2'd0: chk(o_cfg_rdata, e[7:0]);
                2'd1: chk(o_io_rdata, e[7:0]);
                2'd2: chk({7'h00, o_address_line_gate}, e[7:0]);
                default: chk({7'h00, o_keyboard_reset_out_n}, e[7:0]);
            endcase
        end
    end

    initial begin
        repeat (100000) @(posedge i_mclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {cyc, n_mismatch, num_checks} = '0;
        seed = 32'ha570b09d;
        {i_rst, i_cfg_wr, i_ctl_wr, i_ctl_is_cmd, i_fw_gate, i_fw_reset_n} = 6'h21;
        {i_cfg_idx, i_cfg_wdata, i_ctl_byte} = {8'hf0, 16'h0000};
        repeat (16) @(negedge i_mclk);
        i_rst = 1'b0;
        note(1, 2'd1, 8'h24);
        note(1, 2'd2, 8'h00);
        note(1, 2'd3, 8'h01);
        cfg(8'hff);
        for (int r = 0; r < 4; r++) begin
            d = 14 * mhz[r];
            p = 6 * mhz[r];
            cfg({r[1:0], 6'h05});
            ctl(1'b1, 8'hfe);
            pulse();
            gak_host_model_inst.reset_req(1'b0);
            note(2, 2'd1, 8'h25);
            pulse();
        end
        cfg(8'h04);
        for (int i = 0; i < 4; i++) begin
            {g, s} = i[1:0];
            fw(g, 1'b1);
            gak_host_model_inst.wr({6'h00, s, 1'b0});
            note(2, 2'd2, {7'h00, g | s});
            note(2, 2'd1, {6'h09, s, 1'b0});
        end
        cfg(8'h00);
        for (int i = 0; i < 6; i++) begin
            {g, s, rn} = 3'($random(seed));
            fw(g, rn);
            gak_host_model_inst.wr({6'h00, s, 1'b1});
            note(2, 2'd2, {7'h00, g});
            note(2, 2'd3, {7'h00, rn});
            repeat (4) @(negedge i_mclk);
        end
        cfg(8'h03);
        for (int i = 0; i < 8; i++) begin
            b = 8'($random(seed));
            fw(~b[1], ~b[0]);
            ctl(1'b1, 8'hd1);
            ctl(1'b0, b);
            note(2, 2'd2, {7'h00, b[1]});
            note(2, 2'd3, {7'h00, b[0]});
        end
        for (int i = 0; i < 400 && q.size() > 0; i++) @(negedge i_mclk);
        if (q.size() > 0) n_mismatch++;
        wrap_up();
    end
endmodule : gak_top_bench

/* dv/gak_top_checker.sv */
// Purpose: Assertions on the gate/keyboard-reset fast path ports
// Assumes: Register shadows follow the write strobes
// Notes:   Pulse timing is checked only when no older pulse can overlap
`timescale 1ns/10ps
module gak_top_checker (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_cfg_wr,
    input wire logic [7:0]  i_cfg_idx,
    input wire logic [7:0]  i_cfg_wdata,
    input wire logic [7:0]  o_cfg_rdata,
    input wire logic        i_io_wr,
    input wire logic [15:0] i_io_addr,
    input wire logic [7:0]  i_io_wdata,
    input wire logic [7:0]  o_io_rdata,
    input wire logic        i_ctl_wr,
    input wire logic        i_ctl_is_cmd,
    input wire logic [7:0]  i_ctl_byte,
    input wire logic        i_fw_gate,
    input wire logic        i_fw_reset_n,
    input wire logic        o_address_line_gate,
    input wire logic        o_keyboard_reset_out_n
);
    logic [7:0] cfg_q, cfg_d;
    logic [9:0] idle_q, idle_d;
    logic       pb_q, pb_d, arm_q, arm_d, pwr, req;
    always_comb begin
        pwr    = i_io_wr && i_io_addr == 16'h0092;
        req    = (pwr && i_io_wdata[0] && !pb_q && cfg_q[2])
              || (i_ctl_wr && i_ctl_is_cmd && i_ctl_byte == 8'hfe && cfg_q[0]);
        cfg_d  = (i_cfg_wr && i_cfg_idx == 8'hf0) ? (i_cfg_wdata & 8'hc7) : cfg_q;
        pb_d   = pwr ? i_io_wdata[0] : pb_q;
        arm_d  = i_ctl_wr ? (i_ctl_is_cmd && i_ctl_byte == 8'hd1) : arm_q;
        idle_d = req ? 10'h000 : idle_q + {9'h000, idle_q != 10'h3ff};
    end
    always_ff @(posedge i_mclk) begin
        cfg_q  <= i_rst ? 8'h00 : cfg_d;
        idle_q <= i_rst ? 10'h3ff : idle_d;
        pb_q   <= i_rst ? 1'b0 : pb_d;
        arm_q  <= i_rst ? 1'b0 : arm_d;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_CFG_RD: assert property (i_cfg_idx == 8'hf0 |=> o_cfg_rdata == $past(cfg_q))
        else $error("config readback wrong");
    AST_PORT_FIXED: assert property (i_io_addr == 16'h0092
        |=> (o_io_rdata & 8'hfc) == 8'h24) else $error("port fixed bits wrong");
    AST_GATE_PORT: assert property (pwr && i_io_wdata[1] && cfg_q[2]
        |-> ##3 o_address_line_gate) else $error("port gate bit not merged");
    AST_GATE_FW: assert property ((cfg_q[2:1] == 2'b00 && $stable(i_fw_gate)) [*4]
        |-> o_address_line_gate == i_fw_gate) else $error("gate not from firmware");
    AST_RST_FW: assert property ((!cfg_q[2] && !cfg_q[0] && $stable(i_fw_reset_n)) [*4]
        |-> o_keyboard_reset_out_n == i_fw_reset_n) else $error("reset not from firmware");
    AST_D1_APPLY: assert property (i_ctl_wr && !i_ctl_is_cmd && arm_q
        && cfg_q[2:0] == 3'b011 |-> ##3 o_address_line_gate == $past(i_ctl_byte[1], 3)
        && o_keyboard_reset_out_n == $past(i_ctl_byte[0], 3)) else $error("D1 data not applied");
    // Timer latches on the request edge, so the output falls delay plus one edges later
    AST_PORT_PULSE: assert property (req && pwr && idle_q > 10'd330
        && cfg_q[7:6] == 2'b11 |-> ##225 o_keyboard_reset_out_n ##1 !o_keyboard_reset_out_n)
        else $error("port pulse timing");
    AST_FE_PULSE: assert property (req && !pwr && idle_q > 10'd330
        && cfg_q[7:6] == 2'b00 |-> ##85 o_keyboard_reset_out_n ##1 !o_keyboard_reset_out_n)
        else $error("FE pulse timing");
endmodule : gak_top_checker

bind gak_top gak_top_checker gak_top_checker_inst (.i_mclk, .i_rst, .i_cfg_wr, .i_cfg_idx,
    .i_cfg_wdata, .o_cfg_rdata, .i_io_wr, .i_io_addr, .i_io_wdata, .o_io_rdata, .i_ctl_wr,
    .i_ctl_is_cmd, .i_ctl_byte, .i_fw_gate, .i_fw_reset_n, .o_address_line_gate,
    .o_keyboard_reset_out_n);

/* logic/gak_defines.svh */
// Purpose: Constants for the gate/keyboard-reset fast path
// Assumes: Included by bare name; definitions only
// Notes:   Times are in microseconds, rates in MHz
`ifndef GAK_DEFINES_SVH
`define GAK_DEFINES_SVH

// Register locations
`define GAK_CFG_IDX          8'hf0
`define GAK_SYS_PORT_ADDR    16'h0092

// Reset values
`define GAK_CFG_RST          8'h00
`define GAK_SYS_PORT_RST     8'h24

// Bits of the system control port that read back as one
`define GAK_SYS_PORT_ONES    8'h24

// Field positions
`define GAK_SYS_GATE_BIT     1
`define GAK_SYS_RSTREQ_BIT   0
`define GAK_D1_GATE_BIT      1
`define GAK_D1_RESET_BIT     0

// Controller commands decoded in hardware
`define GAK_CMD_GATE_WRITE   8'hd1
`define GAK_CMD_PULSE_RESET  8'hfe

// Reset pulse timing, least values
`define GAK_RST_DELAY_US     14
`define GAK_RST_PULSE_US     6

// Controller clock rates per rate-select code
`define GAK_RATE0_MHZ        6
`define GAK_RATE1_MHZ        8
`define GAK_RATE2_MHZ        12
`define GAK_RATE3_MHZ        16

// Width of the pulse timer counters
`define GAK_CNT_W            12

`endif

/* logic/gak_pkg.sv */
// Purpose: Types for the gate/keyboard-reset fast path
// Assumes: Used only as gak_pkg::name
// Notes:   Struct layouts mirror the register bit maps
package gak_pkg;

    typedef enum logic [1:0] {
        GAK_RATE_6M  = 2'b00,
        GAK_RATE_8M  = 2'b01,
        GAK_RATE_12M = 2'b10,
        GAK_RATE_16M = 2'b11
    } gak_rate_e;

    typedef enum logic [1:0] {
        GAK_TMR_IDLE  = 2'b00,
        GAK_TMR_DELAY = 2'b01,
        GAK_TMR_PULSE = 2'b10
    } gak_tmr_e;

    typedef struct packed {
        gak_rate_e  clock_rate_sel;     // clock_rate_sel_hi, clock_rate_sel_lo
        logic [2:0] rsvd;
        logic       system_port_enable;
        logic       hw_gate_select;
        logic       hw_reset_select;
    } gak_cfg_s;

    typedef struct packed {
        logic [5:0] rsvd;
        logic       special_gate_bit;
        logic       reset_request_bit;
    } gak_sys_port_s;

endpackage : gak_pkg

/* logic/gak_pulse_timer.sv */
// Purpose: Delayed high-going pulse generator for the low reset pulse
// Assumes: Counts are latched at start and are at least one
// Notes:   Starts while busy are ignored
`timescale 1ns/10ps
`include "gak_defines.svh"

module gak_pulse_timer #(
    parameter int CW = `GAK_CNT_W
) (
    input  wire logic          i_mclk,
    input  wire logic          i_rst,
    input  wire logic          i_start,
    input  wire logic [CW-1:0] i_delay_cyc,
    input  wire logic [CW-1:0] i_pulse_cyc,
    output logic               o_pulse
);

    gak_pkg::gak_tmr_e state_q, state_d;
    logic [CW-1:0]     cnt_q,   cnt_d;
    logic [CW-1:0]     pulse_q, pulse_d;
    logic              out_q,   out_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pulse_d = pulse_q;
        out_d   = 1'b0;
        case (state_q)
            gak_pkg::GAK_TMR_IDLE: begin
                if (i_start) begin
                    state_d = gak_pkg::GAK_TMR_DELAY;
                    cnt_d   = i_delay_cyc;
                    pulse_d = i_pulse_cyc;
                end
            end
            gak_pkg::GAK_TMR_DELAY: begin
                if (cnt_q <= CW'(1)) begin
                    state_d = gak_pkg::GAK_TMR_PULSE;
                    cnt_d   = pulse_q;
                    out_d   = 1'b1;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            gak_pkg::GAK_TMR_PULSE: begin
                if (cnt_q <= CW'(1)) begin
                    state_d = gak_pkg::GAK_TMR_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                    out_d = 1'b1;
                end
            end
            default: begin
                state_d = gak_pkg::GAK_TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_q <= gak_pkg::GAK_TMR_IDLE;
            cnt_q   <= '0;
            pulse_q <= '0;
            out_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
            out_q   <= out_d;
        end
    end

    assign o_pulse = out_q;

endmodule : gak_pulse_timer

/* logic/gak_top.sv */
// Purpose: Fast-path control of the address-line gate and keyboard reset
// Assumes: Register strobes and command bytes arrive on i_mclk
// Notes:   i_mclk is taken to run at the rate the rate field names
//
// What this block does
// - Two-bit rate field picks controller clock: 6, 8, 12 or 16 MHz.
// - System-port enable lets the port drive outputs; clear disables it.
// - Hardware-gate select hands the gate output to the command decoder.
// - Hardware-reset select hands the reset output to the command decoder.
// - Data byte after D1 sets gate to its bit 1.
// - With hardware reset selected, that byte's bit 0 sets reset.
// - Command FE waits 14 us, then pulses reset low for 6 us.
// - Firmware path or hardware path owns each output, never both.
// - With port enabled, port requests merge with controller outputs.
// - Port resets to 0x24; reserved bits read fixed values.
// - Port gate bit written 1 drives gate high; 0 leaves it to the controller.
// - Port reset-request bit set waits 14 us, pulses reset 6 us.
`timescale 1ns/10ps
`include "gak_defines.svh"

module gak_top (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Configuration register access
    input  wire logic        i_cfg_wr,
    input  wire logic [7:0]  i_cfg_idx,
    input  wire logic [7:0]  i_cfg_wdata,
    output logic      [7:0]  o_cfg_rdata,
    // System I/O access
    input  wire logic        i_io_wr,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [7:0]  i_io_wdata,
    output logic      [7:0]  o_io_rdata,
    // Bytes accepted by the keyboard controller
    input  wire logic        i_ctl_wr,
    input  wire logic        i_ctl_is_cmd,
    input  wire logic [7:0]  i_ctl_byte,
    // Firmware-driven levels from the controller output port
    input  wire logic        i_fw_gate,
    input  wire logic        i_fw_reset_n,
    // Pins
    output logic             o_address_line_gate,
    output logic             o_keyboard_reset_out_n
);

    localparam int CW = `GAK_CNT_W;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Cycles for a least time at the selected rate; t_us * MHz is exact
    function automatic logic [CW-1:0] gak_cycles(input gak_pkg::gak_rate_e rate,
                                                 input int unsigned        t_us);
        int unsigned mhz;
        case (rate)
            gak_pkg::GAK_RATE_6M:  mhz = `GAK_RATE0_MHZ;
            gak_pkg::GAK_RATE_8M:  mhz = `GAK_RATE1_MHZ;
            gak_pkg::GAK_RATE_12M: mhz = `GAK_RATE2_MHZ;
            gak_pkg::GAK_RATE_16M: mhz = `GAK_RATE3_MHZ;
            default:               mhz = `GAK_RATE3_MHZ;
        endcase
        return CW'(t_us * mhz);
    endfunction : gak_cycles

    function automatic logic [7:0] gak_sys_read(input gak_pkg::gak_sys_port_s p);
        logic [7:0] v;
        v = `GAK_SYS_PORT_ONES;
        v[`GAK_SYS_GATE_BIT]   = p.special_gate_bit;
        v[`GAK_SYS_RSTREQ_BIT] = p.reset_request_bit;
        return v;
    endfunction : gak_sys_read

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    gak_pkg::gak_cfg_s      cfg_q, cfg_d;
    gak_pkg::gak_sys_port_s sys_q, sys_d;
    logic [7:0]             cfg_rdata_q, cfg_rdata_d;
    logic [7:0]             io_rdata_q,  io_rdata_d;
    logic                   sys_hit;
    logic                   sys_req_start;

    assign sys_hit = i_io_wr && (i_io_addr == `GAK_SYS_PORT_ADDR);

    always_comb begin
        cfg_d = cfg_q;
        sys_d = sys_q;
        if (i_cfg_wr && (i_cfg_idx == `GAK_CFG_IDX)) begin
            cfg_d      = gak_pkg::gak_cfg_s'(i_cfg_wdata);
            cfg_d.rsvd = 3'h0;
        end
        if (sys_hit) begin
            // Only the two control bits are writable
            sys_d.special_gate_bit  = i_io_wdata[`GAK_SYS_GATE_BIT];
            sys_d.reset_request_bit = i_io_wdata[`GAK_SYS_RSTREQ_BIT];
        end
        cfg_rdata_d = (i_cfg_idx == `GAK_CFG_IDX) ? cfg_q : 8'h00;
        io_rdata_d  = (i_io_addr == `GAK_SYS_PORT_ADDR) ? gak_sys_read(sys_q)
                                                        : 8'h00;
    end

    // A new request needs a 0 to 1 change, so the host must clear first
    assign sys_req_start = cfg_q.system_port_enable && sys_d.reset_request_bit
                           && !sys_q.reset_request_bit;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_q       <= gak_pkg::gak_cfg_s'(`GAK_CFG_RST);
            sys_q       <= gak_pkg::gak_sys_port_s'(`GAK_SYS_PORT_RST);
            cfg_rdata_q <= 8'h00;
            io_rdata_q  <= 8'h00;
        end else begin
            cfg_q       <= cfg_d;
            sys_q       <= sys_d;
            cfg_rdata_q <= cfg_rdata_d;
            io_rdata_q  <= io_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timing derived from the selected rate

    logic [CW-1:0] delay_cyc;
    logic [CW-1:0] pulse_cyc;

    assign delay_cyc = gak_cycles(cfg_q.clock_rate_sel, `GAK_RST_DELAY_US);
    assign pulse_cyc = gak_cycles(cfg_q.clock_rate_sel, `GAK_RST_PULSE_US);

    ////////////////////////////////////////////////////////////////////////////
    // Hardware command decode

    logic expect_d1_q, expect_d1_d;
    logic hw_gate_q,   hw_gate_d;
    logic hw_rst_n_q,  hw_rst_n_d;
    logic fe_start;

    always_comb begin
        expect_d1_d = expect_d1_q;
        hw_gate_d   = hw_gate_q;
        hw_rst_n_d  = hw_rst_n_q;
        if (i_ctl_wr) begin
            if (i_ctl_is_cmd) begin
                // Any command but D1 cancels a pending D1 data phase
                expect_d1_d = (i_ctl_byte == `GAK_CMD_GATE_WRITE);
            end else if (expect_d1_q) begin
                expect_d1_d = 1'b0;
                if (cfg_q.hw_gate_select) begin
                    hw_gate_d = i_ctl_byte[`GAK_D1_GATE_BIT];
                end
                if (cfg_q.hw_reset_select) begin
                    hw_rst_n_d = i_ctl_byte[`GAK_D1_RESET_BIT];
                end
            end
        end
    end

    assign fe_start = i_ctl_wr && i_ctl_is_cmd && cfg_q.hw_reset_select
                      && (i_ctl_byte == `GAK_CMD_PULSE_RESET);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            expect_d1_q <= 1'b0;
            hw_gate_q   <= 1'b0;
            hw_rst_n_q  <= 1'b1;
        end else begin
            expect_d1_q <= expect_d1_d;
            hw_gate_q   <= hw_gate_d;
            hw_rst_n_q  <= hw_rst_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse generators

    logic fe_pulse;
    logic sys_pulse;

    gak_pulse_timer #(
        .CW          (CW)
    ) u_fe_timer (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_start     (fe_start),
        .i_delay_cyc (delay_cyc),
        .i_pulse_cyc (pulse_cyc),
        .o_pulse     (fe_pulse)
    );

    gak_pulse_timer #(
        .CW          (CW)
    ) u_sys_timer (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_start     (sys_req_start),
        .i_delay_cyc (delay_cyc),
        .i_pulse_cyc (pulse_cyc),
        .o_pulse     (sys_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output merge

    logic gate_q,  gate_d;
    logic rst_n_q, rst_n_d;
    logic ctl_gate;
    logic ctl_rst_n;

    always_comb begin
        // One owner per output; the select bit picks it
        ctl_gate  = cfg_q.hw_gate_select  ? hw_gate_q : i_fw_gate;
        ctl_rst_n = cfg_q.hw_reset_select ? (hw_rst_n_q && !fe_pulse)
                                          : i_fw_reset_n;
        gate_d  = ctl_gate;
        rst_n_d = ctl_rst_n;
        if (cfg_q.system_port_enable) begin
            gate_d  = ctl_gate || sys_q.special_gate_bit;
            rst_n_d = ctl_rst_n && !sys_pulse;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            gate_q  <= 1'b0;
            rst_n_q <= 1'b1;
        end else begin
            gate_q  <= gate_d;
            rst_n_q <= rst_n_d;
        end
    end

    assign o_address_line_gate    = gate_q;
    assign o_keyboard_reset_out_n = rst_n_q;
    assign o_cfg_rdata            = cfg_rdata_q;
    assign o_io_rdata             = io_rdata_q;

endmodule : gak_top
